// ### tcd_pkg.sv
// Constants and types for the texel compare and colour decode block.
`default_nettype none
package tcd_pkg;
	// ==================================================
	// Register word addresses
	localparam logic [3:0] ADDR_SAMPLER = 4'h0;
	localparam logic [3:0] ADDR_LOD = 4'h1;
	localparam logic [3:0] ADDR_LEVEL = 4'h2;
	localparam logic [3:0] ADDR_COMPARE = 4'h3;
	localparam logic [3:0] ADDR_SWIZZLE = 4'h4;
	localparam logic [3:0] ADDR_IMAGE = 4'h5;
	localparam logic [3:0] ADDR_DIMS = 4'h6;
	localparam logic [3:0] ADDR_DEPTH_LEVELS = 4'h7;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_IMAGE_SIZE = 4'h9;
	// ==================================================
	// Field positions
	localparam int F_MIN = 0;
	localparam int F_MAG = 4;
	localparam int F_WRAP_S = 8;
	localparam int F_WRAP_T = 10;
	localparam int F_WRAP_R = 12;
	localparam int F_CMP_FUNC = 4;
	localparam int F_DS_MODE = 8;
	localparam int F_SWZ_G = 4;
	localparam int F_SWZ_B = 8;
	localparam int F_SWZ_A = 12;
	localparam int F_HI = 16;
	// ==================================================
	// Reset values
	localparam logic [2:0] MIN_FILTER_RST = 3'h4;
	localparam logic MAG_FILTER_RST = 1'b1;
	localparam logic [1:0] WRAP_RST = 2'h0;
	localparam logic [15:0] LOD_MIN_RST = 16'hFC18;
	localparam logic [15:0] LOD_MAX_RST = 16'h03E8;
	localparam logic [15:0] BASE_LEVEL_RST = 16'h0000;
	localparam logic [15:0] MAX_LEVEL_RST = 16'h03E8;
	// ==================================================
	// Encodings
	localparam logic [2:0] MIN_NEAREST = 3'h0;
	localparam logic [2:0] MIN_NEAREST_MIP_NEAREST = 3'h2;
	localparam logic MAG_NEAREST = 1'b0;
	typedef enum logic [3:0] {
		FMT_RGBA8 = 4'h0, FMT_GAMMA_RGB8 = 4'h1, FMT_GAMMA_RGBA8 = 4'h2,
		FMT_GAMMA_BLK_RGB = 4'h3, FMT_GAMMA_BLK_RGBA = 4'h4, FMT_GAMMA_BLK_PUNCH = 4'h5,
		FMT_SHARED_EXP = 4'h6, FMT_DEPTH_FIXED = 4'h7, FMT_DEPTH_FLOAT = 4'h8,
		FMT_DS_FIXED = 4'h9, FMT_DS_FLOAT = 4'hA
	} tcd_fmt_e;
	typedef enum logic [2:0] {
		CMP_LESS_OR_EQUAL = 3'h0, CMP_GREATER_OR_EQUAL = 3'h1, CMP_LESS = 3'h2,
		CMP_GREATER = 3'h3, CMP_EQUAL = 3'h4, CMP_NOT_EQUAL = 3'h5,
		CMP_ALWAYS = 3'h6, CMP_NEVER = 3'h7
	} tcd_cmp_e;
	typedef enum logic [2:0] {
		SWZ_RED = 3'h0, SWZ_GREEN = 3'h1, SWZ_BLUE = 3'h2, SWZ_ALPHA = 3'h3,
		SWZ_ZERO = 3'h4, SWZ_ONE = 3'h5
	} tcd_swz_e;
	typedef enum logic [1:0] {
		ERR_NONE = 2'h0, ERR_INVALID_OPERATION = 2'h1, ERR_INVALID_VALUE = 2'h2
	} tcd_err_e;
	typedef enum logic [1:0] {
		TGT_2D = 2'h0, TGT_VOLUME = 2'h1, TGT_LAYERED = 2'h2
	} tcd_tgt_e;
	// ==================================================
	// Numeric constants
	localparam logic [31:0] FP_ONE = 32'h3F800000;
	localparam logic [31:0] FP_ZERO = 32'h00000000;
	localparam int SHARED_EXP_BIAS = 15;
	localparam int SHARED_MANT_BITS = 9;
	localparam int FP_EXP_BIAS = 127;
	localparam real GAMMA_DIV = 12.92;
	localparam real GAMMA_KNEE = 0.04045;
	localparam real GAMMA_OFS = 0.055;
	localparam real GAMMA_SCALE = 1.055;
	localparam real GAMMA_POW = 2.4;
endpackage
`default_nettype wire

// ### tcd_top.sv
// Texel compare, colour decode and texture parameter state.
`timescale 1ns/100ps
`default_nettype none
module tcd_top (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_cmd_valid,
	input wire logic i_cmd_storage,
	input wire logic [1:0] i_cmd_target,
	input wire logic [3:0] i_cmd_format,
	input wire logic [15:0] i_cmd_levels,
	input wire logic [15:0] i_cmd_width,
	input wire logic [15:0] i_cmd_height,
	input wire logic [15:0] i_cmd_depth,
	input wire logic i_cmd_compressed,
	input wire logic [31:0] i_cmd_image_size,
	output logic o_cmd_done,
	output logic [1:0] o_cmd_error,
	input wire logic i_lookup_valid,
	input wire logic [31:0] i_dref,
	input wire logic [31:0] i_sample0,
	input wire logic [31:0] i_sample1,
	input wire logic [31:0] i_sample2,
	input wire logic [31:0] i_sample3,
	input wire logic [7:0] i_stencil,
	output logic o_texel_valid,
	output logic [31:0] o_red,
	output logic [31:0] o_green,
	output logic [31:0] o_blue,
	output logic [31:0] o_alpha
);
	// ==================================================
	// Helper functions
	function automatic logic [15:0] gamma_entry(input int code);
		real cs;
		real cl;
		cs = code / 255.0;
		if (cs <= tcd_pkg::GAMMA_KNEE) begin
			cl = cs / tcd_pkg::GAMMA_DIV;
		end else begin
			cl = ((cs + tcd_pkg::GAMMA_OFS) / tcd_pkg::GAMMA_SCALE) ** tcd_pkg::GAMMA_POW;
		end
		return 16'($rtoi(cl * 65535.0 + 0.5));
	endfunction

	function automatic logic [31:0] shared_to_float(input logic [8:0] m, input logic [4:0] e);
		logic [31:0] f;
		logic [8:0] t;
		int p;
		f = tcd_pkg::FP_ZERO;
		p = 0;
		for (int k = 0; k < tcd_pkg::SHARED_MANT_BITS; k++) begin
			if (m[k]) begin
				p = k;
			end
		end
		if (m != 9'h000) begin
			t = m << (8 - p);
			f[22:0] = {t[7:0], 15'h0000};
			f[30:23] = 8'(int'(e) - tcd_pkg::SHARED_EXP_BIAS - tcd_pkg::SHARED_MANT_BITS
				+ p + tcd_pkg::FP_EXP_BIAS);
		end
		return f;
	endfunction

	function automatic logic [31:0] order_key(input logic [31:0] f);
		return f[31] ? ~f : (f | 32'h80000000);
	endfunction

	function automatic logic [31:0] clamp_unit(input logic [31:0] f);
		if (f[31]) begin
			return tcd_pkg::FP_ZERO;
		end
		return (f > tcd_pkg::FP_ONE) ? tcd_pkg::FP_ONE : f;
	endfunction

	function automatic logic passes(input logic [2:0] fn, input logic [31:0] r, input logic [31:0] d);
		logic [31:0] kr;
		logic [31:0] kd;
		logic ok;
		kr = order_key(r);
		kd = order_key(d);
		unique case (tcd_pkg::tcd_cmp_e'(fn))
			tcd_pkg::CMP_LESS_OR_EQUAL: ok = kr <= kd;
			tcd_pkg::CMP_GREATER_OR_EQUAL: ok = kr >= kd;
			tcd_pkg::CMP_LESS: ok = kr < kd;
			tcd_pkg::CMP_GREATER: ok = kr > kd;
			tcd_pkg::CMP_EQUAL: ok = kr == kd;
			tcd_pkg::CMP_NOT_EQUAL: ok = kr != kd;
			tcd_pkg::CMP_ALWAYS: ok = 1'b1;
			tcd_pkg::CMP_NEVER: ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic int floor_log2(input logic [15:0] v);
		int p;
		p = 0;
		for (int k = 0; k < 16; k++) begin
			if (v[k]) begin
				p = k;
			end
		end
		return p;
	endfunction

	function automatic logic [5:0] comp_bits(input logic [3:0] f);
		unique case (f)
			tcd_pkg::FMT_SHARED_EXP: return 6'h09;
			tcd_pkg::FMT_DEPTH_FIXED, tcd_pkg::FMT_DS_FIXED: return 6'h18;
			tcd_pkg::FMT_DEPTH_FLOAT, tcd_pkg::FMT_DS_FLOAT: return 6'h20;
			default: return 6'h08;
		endcase
	endfunction

	// ==================================================
	// Gamma lookup table, built from the transfer curve at elaboration.
	logic [15:0] gamma_lut [256];
	for (genvar gi = 0; gi < 256; gi++) begin : g_gamma
		localparam logic [15:0] ENTRY = gamma_entry(gi);
		assign gamma_lut[gi] = ENTRY;
	end

	// ==================================================
	// Sampling parameters
	logic [2:0] min_filter_reg;
	logic mag_filter_reg;
	logic [1:0] wrap_s_reg;
	logic [1:0] wrap_t_reg;
	logic [1:0] wrap_r_reg;
	logic [15:0] lod_min_reg;
	logic [15:0] lod_max_reg;
	logic [15:0] base_level_reg;
	logic [15:0] max_level_reg;
	logic compare_mode_reg;
	logic [2:0] compare_func_reg;
	logic stencil_view_reg;
	logic [2:0] swz_reg [4];

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			min_filter_reg <= tcd_pkg::MIN_FILTER_RST;
			mag_filter_reg <= tcd_pkg::MAG_FILTER_RST;
			wrap_s_reg <= tcd_pkg::WRAP_RST;
			wrap_t_reg <= tcd_pkg::WRAP_RST;
			wrap_r_reg <= tcd_pkg::WRAP_RST;
			lod_min_reg <= tcd_pkg::LOD_MIN_RST;
			lod_max_reg <= tcd_pkg::LOD_MAX_RST;
			base_level_reg <= tcd_pkg::BASE_LEVEL_RST;
			max_level_reg <= tcd_pkg::MAX_LEVEL_RST;
			compare_mode_reg <= 1'b0;
			compare_func_reg <= tcd_pkg::CMP_LESS_OR_EQUAL;
			stencil_view_reg <= 1'b0;
			swz_reg[0] <= tcd_pkg::SWZ_RED;
			swz_reg[1] <= tcd_pkg::SWZ_GREEN;
			swz_reg[2] <= tcd_pkg::SWZ_BLUE;
			swz_reg[3] <= tcd_pkg::SWZ_ALPHA;
		end else if (i_ce && i_wr) begin
			unique case (i_addr)
				tcd_pkg::ADDR_SAMPLER: begin
					min_filter_reg <= i_wdata[tcd_pkg::F_MIN +: 3];
					mag_filter_reg <= i_wdata[tcd_pkg::F_MAG];
					wrap_s_reg <= i_wdata[tcd_pkg::F_WRAP_S +: 2];
					wrap_t_reg <= i_wdata[tcd_pkg::F_WRAP_T +: 2];
					wrap_r_reg <= i_wdata[tcd_pkg::F_WRAP_R +: 2];
				end
				tcd_pkg::ADDR_LOD: begin
					lod_min_reg <= i_wdata[15:0];
					lod_max_reg <= i_wdata[tcd_pkg::F_HI +: 16];
				end
				tcd_pkg::ADDR_LEVEL: begin
					base_level_reg <= i_wdata[15:0];
					max_level_reg <= i_wdata[tcd_pkg::F_HI +: 16];
				end
				tcd_pkg::ADDR_COMPARE: begin
					compare_mode_reg <= i_wdata[0];
					compare_func_reg <= i_wdata[tcd_pkg::F_CMP_FUNC +: 3];
					stencil_view_reg <= i_wdata[tcd_pkg::F_DS_MODE];
				end
				tcd_pkg::ADDR_SWIZZLE: begin
					swz_reg[0] <= i_wdata[2:0];
					swz_reg[1] <= i_wdata[tcd_pkg::F_SWZ_G +: 3];
					swz_reg[2] <= i_wdata[tcd_pkg::F_SWZ_B +: 3];
					swz_reg[3] <= i_wdata[tcd_pkg::F_SWZ_A +: 3];
				end
				default: begin
				end
			endcase
		end
	end

	// ==================================================
	// Image descriptor and storage commands
	logic [15:0] img_width_reg;
	logic [15:0] img_height_reg;
	logic [15:0] img_depth_reg;
	logic [3:0] img_format_reg;
	logic [5:0] img_bits_reg;
	logic img_typed_reg;
	logic img_compressed_reg;
	logic [31:0] img_size_reg;
	logic immutable_reg;
	logic [15:0] immutable_levels_reg;
	logic [1:0] last_error_reg;
	logic [15:0] dim_max;
	logic [1:0] cmd_error;

	always_comb begin
		dim_max = (i_cmd_width > i_cmd_height) ? i_cmd_width : i_cmd_height;
		if (i_cmd_target == tcd_pkg::TGT_VOLUME && i_cmd_depth > dim_max) begin
			dim_max = i_cmd_depth;
		end
		cmd_error = tcd_pkg::ERR_NONE;
		if (immutable_reg) begin
			cmd_error = tcd_pkg::ERR_INVALID_OPERATION;
		end else if (i_cmd_width == 16'h0000 || i_cmd_height == 16'h0000
			|| i_cmd_depth == 16'h0000 || (i_cmd_storage && i_cmd_levels == 16'h0000)) begin
			cmd_error = tcd_pkg::ERR_INVALID_VALUE;
		end else if (i_cmd_storage && 32'(i_cmd_levels) > 32'(floor_log2(dim_max) + 1)) begin
			cmd_error = tcd_pkg::ERR_INVALID_OPERATION;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			img_width_reg <= 16'h0000;
			img_height_reg <= 16'h0000;
			img_depth_reg <= 16'h0000;
			img_format_reg <= tcd_pkg::FMT_RGBA8;
			img_bits_reg <= 6'h00;
			img_typed_reg <= 1'b0;
			img_compressed_reg <= 1'b0;
			img_size_reg <= 32'h00000000;
			immutable_reg <= 1'b0;
			immutable_levels_reg <= 16'h0000;
		end else if (i_ce && i_cmd_valid && cmd_error == tcd_pkg::ERR_NONE) begin
			img_width_reg <= i_cmd_width;
			img_height_reg <= i_cmd_height;
			img_depth_reg <= i_cmd_depth;
			img_format_reg <= i_cmd_format;
			img_bits_reg <= comp_bits(i_cmd_format);
			img_typed_reg <= 1'b1;
			img_compressed_reg <= i_cmd_compressed;
			img_size_reg <= i_cmd_compressed ? i_cmd_image_size : 32'h00000000;
			if (i_cmd_storage) begin
				immutable_reg <= 1'b1;
				immutable_levels_reg <= i_cmd_levels;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_cmd_done <= 1'b0;
			o_cmd_error <= tcd_pkg::ERR_NONE;
			last_error_reg <= tcd_pkg::ERR_NONE;
		end else if (i_ce) begin
			o_cmd_done <= i_cmd_valid;
			if (i_cmd_valid) begin
				o_cmd_error <= cmd_error;
				last_error_reg <= cmd_error;
			end
		end
	end

	// ==================================================
	// Register read port
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 32'h00000000;
		end else if (i_ce) begin
			o_rdata <= 32'h00000000;
			if (i_rd) begin
				unique case (i_addr)
					tcd_pkg::ADDR_SAMPLER: o_rdata <= {18'h00000, wrap_r_reg, wrap_t_reg,
						wrap_s_reg, 3'h0, mag_filter_reg, 1'b0, min_filter_reg};
					tcd_pkg::ADDR_LOD: o_rdata <= {lod_max_reg, lod_min_reg};
					tcd_pkg::ADDR_LEVEL: o_rdata <= {max_level_reg, base_level_reg};
					tcd_pkg::ADDR_COMPARE: o_rdata <= {23'h000000, stencil_view_reg, 1'b0,
						compare_func_reg, 3'h0, compare_mode_reg};
					tcd_pkg::ADDR_SWIZZLE: o_rdata <= {17'h00000, swz_reg[3], 1'b0, swz_reg[2],
						1'b0, swz_reg[1], 1'b0, swz_reg[0]};
					tcd_pkg::ADDR_IMAGE: o_rdata <= {16'h0000, img_compressed_reg, img_typed_reg,
						img_bits_reg, 4'h0, img_format_reg};
					tcd_pkg::ADDR_DIMS: o_rdata <= {img_height_reg, img_width_reg};
					tcd_pkg::ADDR_DEPTH_LEVELS: o_rdata <= {immutable_levels_reg, img_depth_reg};
					tcd_pkg::ADDR_STATUS: o_rdata <= {29'h00000000, last_error_reg, immutable_reg};
					tcd_pkg::ADDR_IMAGE_SIZE: o_rdata <= img_size_reg;
					default: o_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ==================================================
	// Lookup datapath
	logic is_depth;
	logic is_stencil_fmt;
	logic is_fixed_depth;
	logic is_gamma;
	logic multi_tap;
	logic [31:0] samp [4];
	logic [31:0] dref_c;
	logic [31:0] dep_c [4];
	logic [3:0] pass;
	logic [2:0] pass_cnt;
	logic [31:0] depth_r;
	logic [31:0] chan [4];
	logic [31:0] swz_out [4];

	assign samp[0] = i_sample0;
	assign samp[1] = i_sample1;
	assign samp[2] = i_sample2;
	assign samp[3] = i_sample3;

	always_comb begin
		is_stencil_fmt = img_format_reg == tcd_pkg::FMT_DS_FIXED
			|| img_format_reg == tcd_pkg::FMT_DS_FLOAT;
		is_depth = is_stencil_fmt || img_format_reg == tcd_pkg::FMT_DEPTH_FIXED
			|| img_format_reg == tcd_pkg::FMT_DEPTH_FLOAT;
		is_fixed_depth = img_format_reg == tcd_pkg::FMT_DEPTH_FIXED
			|| img_format_reg == tcd_pkg::FMT_DS_FIXED;
		is_gamma = img_format_reg >= tcd_pkg::FMT_GAMMA_RGB8
			&& img_format_reg <= tcd_pkg::FMT_GAMMA_BLK_PUNCH;
		multi_tap = !(mag_filter_reg == tcd_pkg::MAG_NEAREST
			&& (min_filter_reg == tcd_pkg::MIN_NEAREST
			|| min_filter_reg == tcd_pkg::MIN_NEAREST_MIP_NEAREST));
		dref_c = is_fixed_depth ? clamp_unit(i_dref) : i_dref;
	end

	for (genvar k = 0; k < 4; k++) begin : g_tap
		assign dep_c[k] = is_fixed_depth ? clamp_unit(samp[k]) : samp[k];
		assign pass[k] = passes(compare_func_reg, dref_c, dep_c[k]);
	end

	always_comb begin
		pass_cnt = 3'(pass[0]) + 3'(pass[1]) + 3'(pass[2]) + 3'(pass[3]);
		if (is_stencil_fmt && stencil_view_reg) begin
			depth_r = {24'h000000, i_stencil};
		end else if (!compare_mode_reg) begin
			depth_r = dep_c[0];
		end else if (multi_tap) begin
			unique case (pass_cnt)
				3'h0: depth_r = tcd_pkg::FP_ZERO;
				3'h1: depth_r = 32'h3E800000;
				3'h2: depth_r = 32'h3F000000;
				3'h3: depth_r = 32'h3F400000;
				default: depth_r = tcd_pkg::FP_ONE;
			endcase
		end else begin
			depth_r = pass[0] ? tcd_pkg::FP_ONE : tcd_pkg::FP_ZERO;
		end
	end

	always_comb begin
		chan[0] = {24'h000000, i_sample0[7:0]};
		chan[1] = {24'h000000, i_sample0[15:8]};
		chan[2] = {24'h000000, i_sample0[23:16]};
		chan[3] = {24'h000000, i_sample0[31:24]};
		if (is_depth) begin
			chan[0] = depth_r;
			chan[1] = tcd_pkg::FP_ZERO;
			chan[2] = tcd_pkg::FP_ZERO;
			chan[3] = tcd_pkg::FP_ONE;
		end else if (is_gamma) begin
			chan[0] = {16'h0000, gamma_lut[i_sample0[7:0]]};
			chan[1] = {16'h0000, gamma_lut[i_sample0[15:8]]};
			chan[2] = {16'h0000, gamma_lut[i_sample0[23:16]]};
		end else if (img_format_reg == tcd_pkg::FMT_SHARED_EXP) begin
			chan[0] = shared_to_float(i_sample0[8:0], i_sample0[31:27]);
			chan[1] = shared_to_float(i_sample0[17:9], i_sample0[31:27]);
			chan[2] = shared_to_float(i_sample0[26:18], i_sample0[31:27]);
			chan[3] = tcd_pkg::FP_ONE;
		end
	end

	for (genvar c = 0; c < 4; c++) begin : g_swz
		always_comb begin
			unique case (swz_reg[c])
				tcd_pkg::SWZ_RED: swz_out[c] = chan[0];
				tcd_pkg::SWZ_GREEN: swz_out[c] = chan[1];
				tcd_pkg::SWZ_BLUE: swz_out[c] = chan[2];
				tcd_pkg::SWZ_ALPHA: swz_out[c] = chan[3];
				tcd_pkg::SWZ_ONE: swz_out[c] = tcd_pkg::FP_ONE;
				default: swz_out[c] = tcd_pkg::FP_ZERO;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_texel_valid <= 1'b0;
			o_red <= 32'h00000000;
			o_green <= 32'h00000000;
			o_blue <= 32'h00000000;
			o_alpha <= 32'h00000000;
		end else if (i_ce) begin
			o_texel_valid <= i_lookup_valid;
			if (i_lookup_valid) begin
				o_red <= swz_out[0];
				o_green <= swz_out[1];
				o_blue <= swz_out[2];
				o_alpha <= swz_out[3];
			end
		end
	end
endmodule
`default_nettype wire

// ### tcd_asserts.sv
// Port checker for the texel compare and colour decode block.
`timescale 1ns/100ps
`default_nettype none
module tcd_asserts (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic i_cmd_valid,
	input wire logic i_cmd_storage,
	input wire logic [3:0] i_cmd_format,
	input wire logic o_cmd_done,
	input wire logic [1:0] o_cmd_error,
	input wire logic i_lookup_valid,
	input wire logic [31:0] i_sample0,
	input wire logic [7:0] i_stencil,
	input wire logic o_texel_valid,
	input wire logic [31:0] o_red,
	input wire logic [31:0] o_green,
	input wire logic [31:0] o_alpha
);
	// ==================================================
	// Shadow of format, compare, swizzle and lock state.
	logic [3:0] fmt_reg;
	logic [3:0] fmt_pend;
	logic st_pend;
	logic lock_reg;
	logic swz_id_reg;
	logic [8:0] cmp_reg;
	logic lk;
	logic dep;
	assign lk = i_ce && i_lookup_valid && swz_id_reg;
	assign dep = fmt_reg >= 4'h7 && fmt_reg <= 4'hA;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			{fmt_reg, fmt_pend, st_pend, lock_reg} <= 10'h0;
			{swz_id_reg, cmp_reg} <= 10'h200;
		end else if (i_ce) begin
			if (i_cmd_valid)
				{fmt_pend, st_pend} <= {i_cmd_format, i_cmd_storage};
			if (o_cmd_done && o_cmd_error == 2'h0) begin
				fmt_reg <= fmt_pend;
				lock_reg <= lock_reg | st_pend;
			end
			if (i_wr && i_addr == tcd_pkg::ADDR_COMPARE)
				cmp_reg <= i_wdata[8:0];
			if (i_wr && i_addr == tcd_pkg::ADDR_SWIZZLE)
				swz_id_reg <= i_wdata[14:0] == 15'h3210;
		end
	end
	// ==================================================
	// Assertions.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	rdata_idle_a: assert property (i_ce && !i_rd |=> o_rdata == 32'h0)
		else $error("read data not zero outside a read answer");
	done_pulse_a: assert property (i_ce |=> o_cmd_done == $past(i_cmd_valid))
		else $error("command done not one cycle after the command");
	texel_pulse_a: assert property (i_ce |=> o_texel_valid == $past(i_lookup_valid))
		else $error("texel valid not one cycle after the lookup");
	error_hold_a: assert property (i_ce && !i_cmd_valid |=> $stable(o_cmd_error))
		else $error("command error changed without a command");
	lock_refuse_a: assert property (
		lock_reg && i_ce && i_cmd_valid |=> o_cmd_error == 2'h1)
		else $error("command on fixed storage not refused");
	bypass_pass_a: assert property (
		lk && fmt_reg == tcd_pkg::FMT_RGBA8 |=> o_red == {24'h0, $past(i_sample0[7:0])}
		&& o_alpha == {24'h0, $past(i_sample0[31:24])})
		else $error("plain texel altered");
	fixed_func_a: assert property (
		lk && dep && cmp_reg[0] && !cmp_reg[8] && cmp_reg[6:5] == 2'b11
		|=> o_red == (cmp_reg[4] ? 32'h0 : 32'h3F800000))
		else $error("always or never result wrong");
	depth_chan_a: assert property (
		lk && dep |=> o_alpha == 32'h3F800000 && o_green == 32'h0)
		else $error("depth result channels wrong");
	gamma_alpha_a: assert property (
		lk && fmt_reg >= 4'h1 && fmt_reg <= 4'h5 |=> o_alpha == {24'h0, $past(i_sample0[31:24])})
		else $error("gamma alpha altered");
	stencil_view_a: assert property (
		lk && fmt_reg >= 4'h9 && fmt_reg <= 4'hA && cmp_reg[8] |=> o_red == {24'h0, $past(i_stencil)})
		else $error("stencil view result wrong");
endmodule
bind tcd_top tcd_asserts chk_u (.*);
`default_nettype wire

// ### tcd_core_model.sv
// Shader core model that issues texture lookups.
`timescale 1ns/100ps
`default_nettype none
module tcd_core_model (
	input wire logic i_clk,
	output logic o_lookup_valid,
	output logic [31:0] o_dref,
	output logic [127:0] o_taps,
	output logic [7:0] o_stencil
);
	initial begin
		{o_lookup_valid, o_dref, o_taps, o_stencil} = '0;
	end
	// Operands are inverted once the pulse ends so stale values never match.
	task automatic lookup(input logic [31:0] d, input logic [127:0] t, input logic [7:0] s);
		@(posedge i_clk);
		{o_lookup_valid, o_dref, o_taps, o_stencil} <= {1'b1, d, t, s};
		@(posedge i_clk);
		{o_lookup_valid, o_dref, o_taps, o_stencil} <= {1'b0, ~d, ~t, ~s};
	endtask
endmodule
`default_nettype wire

// ### texel_compare_and_color_decode_tb.sv
// Self-checking bench of the texel compare and colour decode block.
`timescale 1ns/100ps
`default_nettype none
module texel_compare_and_color_decode_tb;
	localparam logic [31:0] ONE = 32'h3F800000;
	localparam logic [31:0] HALF = 32'h3F000000;
	localparam logic [31:0] QTR = 32'h3E800000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic c_v = 1'b0;
	logic c_st = 1'b0;
	logic [1:0] c_tg = 2'h0;
	logic [3:0] c_f = 4'h0;
	logic [63:0] c_dim = 64'h0;
	logic [31:0] rdata, red, grn, blu, alp, dref;
	logic [127:0] taps;
	logic [7:0] st;
	logic done, tv, lv;
	logic [1:0] err;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	tcd_core_model core_u (.i_clk(clk), .o_lookup_valid(lv), .o_dref(dref), .o_taps(taps),
		.o_stencil(st));
	tcd_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_cmd_valid(c_v), .i_cmd_storage(c_st),
		.i_cmd_target(c_tg), .i_cmd_format(c_f), .i_cmd_levels(c_dim[63:48]),
		.i_cmd_width(c_dim[47:32]), .i_cmd_height(c_dim[31:16]), .i_cmd_depth(c_dim[15:0]),
		.i_cmd_compressed(1'b0), .i_cmd_image_size(32'h0), .o_cmd_done(done),
		.o_cmd_error(err), .i_lookup_valid(lv), .i_dref(dref), .i_sample0(taps[31:0]),
		.i_sample1(taps[63:32]), .i_sample2(taps[95:64]), .i_sample3(taps[127:96]),
		.i_stencil(st), .o_texel_valid(tv), .o_red(red), .o_green(grn), .o_blue(blu),
		.o_alpha(alp));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		{addr, wdata, wr_s} <= {a, d, 1'b1};
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		{addr, rd_s} <= {a, 1'b1};
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	task automatic cmd(input logic s, input logic [1:0] t, input logic [3:0] f,
		input logic [63:0] dm, input logic [1:0] e);
		@(posedge clk);
		{c_v, c_st, c_tg, c_f, c_dim} <= {1'b1, s, t, f, dm};
		@(posedge clk);
		c_v <= 1'b0;
		#1 chk("cmd_done", 32'h1, {31'h0, done});
		chk("cmd_error", {30'h0, e}, {30'h0, err});
	endtask
	task automatic lk(input logic [31:0] d, input logic [127:0] t, input logic [7:0] s,
		input logic [31:0] e);
		core_u.lookup(d, t, s);
		#1 chk("texel_valid", 32'h1, {31'h0, tv});
		chk("red", e, red);
	endtask
	function automatic logic [31:0] gam(input int c);
		real s;
		s = c / 255.0;
		s = (s <= 0.04045) ? s / 12.92 : ((s + 0.055) / 1.055) ** 2.4;
		return $rtoi(s * 65535.0 + 0.5);
	endfunction
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(tcd_pkg::ADDR_SAMPLER, 32'h00000014);
		rd(tcd_pkg::ADDR_LOD, 32'h03E8FC18);
		rd(tcd_pkg::ADDR_LEVEL, 32'h03E80000);
		rd(tcd_pkg::ADDR_COMPARE, 32'h0);
		rd(tcd_pkg::ADDR_SWIZZLE, 32'h00003210);
		for (int a = 5; a < 11; a++)
			rd(a[3:0], 32'h0);
		// Single-tap compare, equal and lower reference, every function.
		cmd(0, 2'h0, tcd_pkg::FMT_DEPTH_FIXED, {16'd1, 16'd4, 16'd4, 16'd1}, 2'h0);
		wr(tcd_pkg::ADDR_SAMPLER, 32'h0);
		rd(tcd_pkg::ADDR_SAMPLER, 32'h0);
		for (int f = 0; f < 8; f++) begin
			wr(tcd_pkg::ADDR_COMPARE, 32'h1 | (f << 4));
			lk(HALF, {96'h0, HALF}, 8'h0, 8'h53 >> f & 1 ? ONE : 32'h0);
			lk(QTR, {96'h0, HALF}, 8'h0, 8'h65 >> f & 1 ? ONE : 32'h0);
		end
		wr(tcd_pkg::ADDR_COMPARE, 32'h11);
		lk(32'hBF800000, 128'h0, 8'h0, ONE);
		wr(tcd_pkg::ADDR_COMPARE, 32'h0);
		lk(HALF, {96'h0, 32'h40000000}, 8'h0, ONE);
		cmd(0, 2'h0, tcd_pkg::FMT_DEPTH_FLOAT, {16'd1, 16'd4, 16'd4, 16'd1}, 2'h0);
		lk(HALF, {96'h0, 32'h40000000}, 8'h0, 32'h40000000);
		cmd(0, 2'h0, tcd_pkg::FMT_RGBA8, {16'd1, 16'd4, 16'd4, 16'd1}, 2'h0);
		wr(tcd_pkg::ADDR_COMPARE, 32'h71);
		lk(HALF, {96'h0, 32'h44332211}, 8'h0, 32'h11);
		// Linear filters make four taps count towards the result.
		cmd(0, 2'h0, tcd_pkg::FMT_DEPTH_FIXED, {16'd1, 16'd4, 16'd4, 16'd1}, 2'h0);
		wr(tcd_pkg::ADDR_SAMPLER, 32'h14);
		wr(tcd_pkg::ADDR_COMPARE, 32'h1);
		lk(HALF, {ONE, 32'h3F400000, HALF, QTR}, 8'h0, 32'h3F400000);
		cmd(0, 2'h0, tcd_pkg::FMT_DS_FIXED, {16'd1, 16'd4, 16'd4, 16'd1}, 2'h0);
		wr(tcd_pkg::ADDR_COMPARE, 32'h101);
		lk(HALF, 128'h0, 8'h5A, 32'h5A);
		for (int f = 1; f < 6; f++) begin
			cmd(0, 2'h0, f[3:0], {16'd1, 16'd4, 16'd4, 16'd1}, 2'h0);
			lk(HALF, {96'h0, 32'h80FF0B0A}, 8'h0, gam(10));
			chk("green", gam(11), grn);
			chk("blue", gam(255), blu);
			chk("alpha", 32'h80, alp);
		end
		cmd(0, 2'h0, tcd_pkg::FMT_SHARED_EXP, {16'd1, 16'd4, 16'd4, 16'd1}, 2'h0);
		lk(HALF, {96'h0, 5'd24, 9'd0, 9'd256, 9'd1}, 8'h0, ONE);
		chk("green", 32'h43800000, grn);
		chk("blue", 32'h0, blu);
		// Level limits, then the storage lock.
		cmd(1, 2'h2, tcd_pkg::FMT_RGBA8, {16'd4, 16'd4, 16'd4, 16'd16}, 2'h1);
		cmd(1, 2'h1, tcd_pkg::FMT_RGBA8, {16'd6, 16'd4, 16'd4, 16'd16}, 2'h1);
		cmd(1, 2'h0, tcd_pkg::FMT_RGBA8, {16'd1, 16'd0, 16'd4, 16'd1}, 2'h2);
		cmd(1, 2'h1, tcd_pkg::FMT_RGBA8, {16'd5, 16'd4, 16'd4, 16'd16}, 2'h0);
		rd(tcd_pkg::ADDR_STATUS, 32'h1);
		rd(tcd_pkg::ADDR_DEPTH_LEVELS, 32'h00050010);
		cmd(0, 2'h1, tcd_pkg::FMT_RGBA8, {16'd5, 16'd4, 16'd4, 16'd16}, 2'h1);
		cmd(1, 2'h1, tcd_pkg::FMT_RGBA8, {16'd5, 16'd4, 16'd4, 16'd16}, 2'h1);
		rd(tcd_pkg::ADDR_STATUS, 32'h3);
		// Swapped, constant-one and constant-zero channel routing on a plain texel.
		wr(tcd_pkg::ADDR_SWIZZLE, 32'h00004501);
		rd(tcd_pkg::ADDR_SWIZZLE, 32'h00004501);
		lk(HALF, {96'h0, 32'h44332211}, 8'h0, 32'h22);
		chk("green", 32'h11, grn);
		chk("blue", ONE, blu);
		chk("alpha", 32'h0, alp);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(tcd_pkg::ADDR_STATUS, 32'h0);
		rd(tcd_pkg::ADDR_SWIZZLE, 32'h00003210);
		// A write while the clock enable is low must leave the limits alone.
		@(posedge clk);
		ce <= 1'b0;
		wr(tcd_pkg::ADDR_LOD, 32'h12345678);
		ce <= 1'b1;
		rd(tcd_pkg::ADDR_LOD, 32'h03E8FC18);
		wrap_up();
	end
endmodule
`default_nettype wire
